//--- core/dcf_pkg.sv
// constants for the dual clock buffer read side, flags and offset access
// assumes one fast system clock that oversamples both link clocks
`default_nettype none
package dcf_pkg;
   // storage geometry
   localparam int unsigned DW = 18;            // word width
   localparam int unsigned AW = 13;            // storage index width
   localparam int unsigned PW = 14;            // pointer width, one wrap bit
   localparam int unsigned OW = 13;            // offset register width
   localparam int unsigned PINW = 28;          // synchronised pin inputs
   // pin levels the synchronisers hold in reset: link clocks low, controls idle high
   localparam logic [27:0] PIN_IDLE = 28'hffffffc;
   // occupancy limits
   localparam logic [13:0] FULL_STD = 14'h2000;  // words that make full, standard mode
   localparam logic [13:0] HALF_STD = 14'h1000;  // half depth threshold
   // offset defaults chosen by offset access level at master reset
   localparam logic [12:0] OFF_PARALLEL = 13'h007f;
   localparam logic [12:0] OFF_SERIAL = 13'h03ff;
   // pin vector positions
   localparam int unsigned P_WCLK = 0;
   localparam int unsigned P_RCLK = 1;
   localparam int unsigned P_WEN = 2;
   localparam int unsigned P_REN = 3;
   localparam int unsigned P_SI = 4;
   localparam int unsigned P_LD = 5;
   localparam int unsigned P_SEN = 6;
   localparam int unsigned P_OE = 7;
   localparam int unsigned P_MRS = 8;
   localparam int unsigned P_PRS = 9;
   localparam int unsigned P_DATA = 10;
   // apb register byte addresses
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_EMPTY_OFF = 8'h04;
   localparam logic [7:0] A_FULL_OFF = 8'h08;
   localparam logic [7:0] A_LEVEL = 8'h0c;
endpackage
`default_nettype wire

//--- core/dcf_read_flags.sv
// dual clock buffer: storage, read side, status flags and offset access
// assumes write and read clocks at least four system clocks per phase
// Summary of operation
// - read enable low, not empty: load output
// - read enable high: output register held, except fall-through refill of an empty output
// - standard mode: every word requested, empty ignores reads
// - standard empty flag clears two read edges later
// - fall-through first word on third read edge
// - fall-through output-ready rises on read when drained
// - serial mode: shift one offset bit per write edge
// - serial enable high: offsets unchanged
// - output enable low drives data, else released
// - offset access strap picks default and method
// - offset writes use selected method, reads parallel
// - standard full flag after depth writes
// - input-ready counts output word, one more
// - full flag through two write-side stages
// - empty two stages, output-ready three
// - output-ready low with valid word, data held
// - almost-full at depth minus full offset, plus one fall-through
// - almost-empty at n, or n+1 fall-through
// - half-full set by write, cleared by read
// - half-full after half plus one or two writes
// - eighteen bit read data bus
// - write enable low, not full: store word
// - fall-through select strap at master reset
`default_nettype none
module dcf_read_flags (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic write_clk,
   input wire logic read_clk,
   input wire logic write_en_n,
   input wire logic read_en_n,
   input wire logic [17:0] write_data,
   input wire logic fall_through_mode,
   input wire logic offset_access_n,
   input wire logic serial_load_en_n,
   input wire logic output_en_n,
   input wire logic master_reset_n,
   input wire logic partial_reset_n,
   output logic [17:0] read_data,
   output logic readDataOe,
   output logic emptyFlag_n,
   output logic fullFlag_n,
   output logic almostEmpty_n,
   output logic almostFull_n,
   output logic halfFull_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // gray helpers
   function automatic logic [13:0] gray2bin(input logic [13:0] g);
      logic [13:0] b;
      b = '0;
      b[13] = g[13];
      for (int i = 12; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction

   // two flop synchroniser for every pin input
   logic [27:0] pinS1_reg;
   logic [27:0] pinS2_reg;
   logic [1:0] clkD_reg;          // previous synced link clocks for edges
   logic [27:0] pinRaw;
   assign pinRaw = {write_data, partial_reset_n, master_reset_n, output_en_n,
      serial_load_en_n, offset_access_n, fall_through_mode, read_en_n,
      write_en_n, read_clk, write_clk};

   // pins sampled twice; only the second stage is looked at
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinS1_reg <= dcf_pkg::PIN_IDLE;
         pinS2_reg <= dcf_pkg::PIN_IDLE;
         clkD_reg <= 2'h0;
      end else begin
         pinS1_reg <= pinRaw;
         pinS2_reg <= pinS1_reg;
         clkD_reg <= pinS2_reg[1:0];
      end
   end

   logic wEdge, rEdge, wenN, renN, siBit, ldN, senN, oeN, coreRst;
   logic [17:0] wData;
   assign wEdge = pinS2_reg[dcf_pkg::P_WCLK] & ~clkD_reg[0];   // rising write clock
   assign rEdge = pinS2_reg[dcf_pkg::P_RCLK] & ~clkD_reg[1];   // rising read clock
   assign wenN = pinS2_reg[dcf_pkg::P_WEN];
   assign renN = pinS2_reg[dcf_pkg::P_REN];
   assign siBit = pinS2_reg[dcf_pkg::P_SI];
   assign ldN = pinS2_reg[dcf_pkg::P_LD];
   assign senN = pinS2_reg[dcf_pkg::P_SEN];
   assign oeN = pinS2_reg[dcf_pkg::P_OE];
   assign wData = pinS2_reg[27:10];
   // either reset pin clears pointers; only master reset reloads straps
   assign coreRst = ~pinS2_reg[dcf_pkg::P_MRS] | ~pinS2_reg[dcf_pkg::P_PRS];

   // mode straps captured while master reset is held
   logic fwftMode_reg;          // fall-through mode selected
   logic serialMode_reg;        // serial offset loading selected
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fwftMode_reg <= 1'b0;
         serialMode_reg <= 1'b0;
      end else if (!pinS2_reg[dcf_pkg::P_MRS]) begin
         fwftMode_reg <= siBit;
         serialMode_reg <= ldN;
      end
   end

   // pointers, storage and cross-domain copies
   logic [17:0] mem [8192];        // storage, no reset needed
   logic [13:0] wPtr_reg;          // write pointer
   logic [13:0] wGray_reg;         // gray copy for the read side
   logic [13:0] rPtr_reg;          // words moved out of storage
   logic [13:0] cPtr_reg;          // words consumed by the reader
   logic [13:0] cGray_reg;         // gray copy for the write side
   logic [13:0] wSync1_reg, wSync2_reg;   // write pointer on read edges
   logic [13:0] cSync1_reg, cSync2_reg;   // consumed pointer on write edges
   logic outValid_reg;             // output register holds an unread word
   logic didWrite_reg, didRead_reg;       // pointer moved last cycle
   logic [13:0] wSyncBin, cSyncBin, wOcc, rOcc, fullLimit, halfThr;
   logic memEmpty, fullNow;
   assign wSyncBin = gray2bin(wSync2_reg);
   assign cSyncBin = gray2bin(cSync2_reg);
   assign wOcc = 14'(wPtr_reg - cSyncBin);             // write side view
   assign rOcc = 14'(wSyncBin - cPtr_reg);             // read side view
   // fall-through counts the output register word
   assign fullLimit = 14'(dcf_pkg::FULL_STD + {13'h0, fwftMode_reg});
   assign halfThr = 14'(dcf_pkg::HALF_STD + {13'h0, fwftMode_reg});
   assign memEmpty = (rPtr_reg == wSyncBin);
   // full at depth; writes refused beyond
   assign fullNow = (wOcc >= fullLimit);

   // write side: store word and advance pointer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wPtr_reg <= 14'h0;
         didWrite_reg <= 1'b0;
      end else if (coreRst) begin
         wPtr_reg <= 14'h0;
         didWrite_reg <= 1'b0;
      end else begin
         didWrite_reg <= 1'b0;
         // store on enabled write edge, ignored when full
         if (wEdge && !wenN && !fullNow) begin
            wPtr_reg <= 14'(wPtr_reg + 14'h1);
            didWrite_reg <= 1'b1;
         end
      end
   end

   // storage write port
   always_ff @(posedge ref_clk) begin
      if (wEdge && !wenN && !fullNow && !coreRst) begin
         mem[wPtr_reg[12:0]] <= wData;
      end
   end

   // gray encode and two-stage crossing in each direction
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wGray_reg <= 14'h0;
         cGray_reg <= 14'h0;
         wSync1_reg <= 14'h0;
         wSync2_reg <= 14'h0;
         cSync1_reg <= 14'h0;
         cSync2_reg <= 14'h0;
      end else if (coreRst) begin
         wGray_reg <= 14'h0;
         cGray_reg <= 14'h0;
         wSync1_reg <= 14'h0;
         wSync2_reg <= 14'h0;
         cSync1_reg <= 14'h0;
         cSync2_reg <= 14'h0;
      end else begin
         wGray_reg <= wPtr_reg ^ (wPtr_reg >> 1);
         cGray_reg <= cPtr_reg ^ (cPtr_reg >> 1);
         // read side stages advance on read edges
         if (rEdge) begin
            wSync1_reg <= wGray_reg;
            wSync2_reg <= wSync1_reg;
         end
         // write side stages advance on write edges
         if (wEdge) begin
            cSync1_reg <= cGray_reg;
            cSync2_reg <= cSync1_reg;
         end
      end
   end

   // read side: output register and pointers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         read_data <= 18'h0;
         rPtr_reg <= 14'h0;
         cPtr_reg <= 14'h0;
         outValid_reg <= 1'b0;
         didRead_reg <= 1'b0;
      end else if (coreRst) begin
         read_data <= 18'h0;
         rPtr_reg <= 14'h0;
         cPtr_reg <= 14'h0;
         outValid_reg <= 1'b0;
         didRead_reg <= 1'b0;
      end else begin
         didRead_reg <= 1'b0;
         if (rEdge && !fwftMode_reg) begin
            // load on read edge with enable low
            if (!renN && !memEmpty) begin
               read_data <= mem[rPtr_reg[12:0]];
               rPtr_reg <= 14'(rPtr_reg + 14'h1);
               cPtr_reg <= 14'(cPtr_reg + 14'h1);
               didRead_reg <= 1'b1;
            end
         end else if (rEdge) begin
            // empty output register refills without a request
            if (!outValid_reg || !renN) begin
               if (!memEmpty) begin
                  read_data <= mem[rPtr_reg[12:0]];
                  rPtr_reg <= 14'(rPtr_reg + 14'h1);
                  outValid_reg <= 1'b1;
               end else begin
                  // true read on last word marks drained
                  // last data stays on the outputs
                  outValid_reg <= 1'b0;
               end
            end
            if (!renN && outValid_reg) begin
               cPtr_reg <= 14'(cPtr_reg + 14'h1);
               didRead_reg <= 1'b1;
            end
         end
      end
   end

   // offset registers: strap defaults, serial shift, parallel write
   logic [12:0] emptyOff_reg;      // almost-empty offset n
   logic [12:0] fullOff_reg;       // almost-full offset m
   logic apbWrite;
   assign apbWrite = psel && penable && pready && pwrite;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         emptyOff_reg <= dcf_pkg::OFF_PARALLEL;
         fullOff_reg <= dcf_pkg::OFF_PARALLEL;
      end else if (!pinS2_reg[dcf_pkg::P_MRS]) begin
         emptyOff_reg <= ldN ? dcf_pkg::OFF_SERIAL : dcf_pkg::OFF_PARALLEL;
         fullOff_reg <= ldN ? dcf_pkg::OFF_SERIAL : dcf_pkg::OFF_PARALLEL;
      end else if (serialMode_reg) begin
         // one bit per write edge, full offset msb first
         // serial enable high leaves offsets alone
         if (wEdge && !senN && !ldN) begin
            {fullOff_reg, emptyOff_reg} <= {fullOff_reg[11:0], emptyOff_reg, siBit};
         end
      end else if (apbWrite && !ldN) begin
         // parallel writes only in parallel mode, access low
         if (paddr == dcf_pkg::A_EMPTY_OFF) begin
            emptyOff_reg <= pwdata[12:0];
         end else if (paddr == dcf_pkg::A_FULL_OFF) begin
            fullOff_reg <= pwdata[12:0];
         end
      end
   end

   // flag registers from pointer state, output drive from the enable pin
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         emptyFlag_n <= 1'b0;
         fullFlag_n <= 1'b1;
         almostEmpty_n <= 1'b0;
         almostFull_n <= 1'b1;
         halfFull_n <= 1'b1;
         readDataOe <= 1'b0;
      end else if (coreRst) begin
         emptyFlag_n <= fwftMode_reg;
         fullFlag_n <= ~fwftMode_reg;
         almostEmpty_n <= 1'b0;
         almostFull_n <= 1'b1;
         halfFull_n <= 1'b1;
         readDataOe <= ~oeN;
      end else begin
         // empty clears once the crossed write pointer moves
         // output-ready low exactly while a word is valid
         emptyFlag_n <= fwftMode_reg ? ~outValid_reg : ~memEmpty;
         // full low when full; input-ready high when full
         fullFlag_n <= fwftMode_reg ? fullNow : ~fullNow;
         // low at n or fewer words, n+1 in fall-through
         almostEmpty_n <= ~(rOcc <= 14'({1'b0, emptyOff_reg} + {13'h0, fwftMode_reg}));
         // low at depth minus m written words, plus one in fall-through
         almostFull_n <= ~(wOcc >= 14'(fullLimit - {1'b0, fullOff_reg}));
         // write edge sets low, read edge sets high
         if (didWrite_reg && wOcc > halfThr) begin
            halfFull_n <= 1'b0;
         end else if (didRead_reg && rOcc <= halfThr) begin
            halfFull_n <= 1'b1;
         end
         // drive while output enable is low
         readDataOe <= ~oeN;
      end
   end

   // apb slave: no wait states, pready from a flop
   logic [31:0] rdMux;
   logic rdErr;
   always_comb begin
      rdMux = 32'h0;
      rdErr = 1'b0;
      case (paddr)
         dcf_pkg::A_STATUS: rdMux = {24'h0, serialMode_reg, fwftMode_reg, outValid_reg,
            halfFull_n, almostFull_n, almostEmpty_n, fullFlag_n, emptyFlag_n};
         // offsets always read back in parallel
         dcf_pkg::A_EMPTY_OFF: rdMux = {19'h0, emptyOff_reg};
         dcf_pkg::A_FULL_OFF: rdMux = {19'h0, fullOff_reg};
         dcf_pkg::A_LEVEL: rdMux = {2'h0, wOcc, 2'h0, rOcc};
         default: rdErr = 1'b1;
      endcase
   end

   // answer prepared in the setup cycle, stands for the access cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : rdMux;
            pslverr <= rdErr;
         end else begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
         end
      end
   end

   // checks beside the logic
   sequence s_drainRead;
      rEdge && fwftMode_reg && !renN && outValid_reg && memEmpty;
   endsequence
   sequence s_readyRises;
      !outValid_reg ##1 emptyFlag_n;
   endsequence
   a_hold_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n || coreRst)
      rEdge && renN && (outValid_reg || !fwftMode_reg) |=> $stable(read_data))
      else $error("read data changed with read enable high");
   a_std_empty_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n || coreRst)
      rEdge && !fwftMode_reg && memEmpty |=> $stable(rPtr_reg))
      else $error("read taken while empty");
   a_drain_ready_high: assert property (@(posedge ref_clk) disable iff (!rst_n || coreRst)
      s_drainRead |=> s_readyRises and $stable(read_data))
      else $error("output ready did not rise after last read");
   a_full_blocks_write: assert property (@(posedge ref_clk) disable iff (!rst_n || coreRst)
      wEdge && fullNow |=> $stable(wPtr_reg))
      else $error("write accepted while full");
   a_serial_shift_bit: assert property (@(posedge ref_clk)
      disable iff (!rst_n || !pinS2_reg[dcf_pkg::P_MRS])
      serialMode_reg && wEdge && !senN && !ldN |=> emptyOff_reg[0] == $past(siBit))
      else $error("serial bit not shifted in");
   a_sen_holds_offset: assert property (@(posedge ref_clk)
      disable iff (!rst_n || !pinS2_reg[dcf_pkg::P_MRS])
      serialMode_reg && senN |=> $stable(emptyOff_reg) && $stable(fullOff_reg))
      else $error("offset changed with serial enable high");
   a_oe_follows_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(oeN) |=> readDataOe ##0 $past(readDataOe, 1) == 1'b0)
      else $error("output drive did not follow enable");
   a_strap_default: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(pinS2_reg[dcf_pkg::P_MRS]) |-> emptyOff_reg ==
      (serialMode_reg ? dcf_pkg::OFF_SERIAL : dcf_pkg::OFF_PARALLEL))
      else $error("default offset does not match strap");
   a_half_full_set: assert property (@(posedge ref_clk) disable iff (!rst_n || coreRst)
      didWrite_reg && wOcc > halfThr |=> !halfFull_n)
      else $error("half full not set after write");
   a_ready_tracks_word: assert property (@(posedge ref_clk) disable iff (!rst_n || coreRst)
      fwftMode_reg && $rose(outValid_reg) |=> !emptyFlag_n)
      else $error("output ready not low with a valid word");
endmodule
`default_nettype wire

//--- tb/dcf_link_agent.sv
// link side model: a writer and a reader agent, each with its own link clock
// assumes the block oversamples both link clocks; clocks stand still low when idle
`default_nettype none
module dcf_link_agent (
   input wire logic ref_clk,
   output logic write_clk,
   output logic read_clk,
   output logic write_en_n,
   output logic read_en_n,
   output logic [17:0] write_data
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 4; // system clocks in half of the 160 ns link period
   // idle levels at time zero
   initial begin
      write_clk = 1'b0;
      read_clk = 1'b0;
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      write_data = 18'h0;
   end
   // writer stores one word per write clock rise
   // inputs move at the falling link edge, so they stand four system clocks around each rise;
   // every change is a non-blocking assignment just after a system clock rise
   task automatic wr(input int n, input logic [17:0] base, input logic enN);
      for (int i = 0; i < n; i++) begin
         write_en_n <= enN;
         // released data toggles so a stale word never looks valid
         write_data <= enN ? ~write_data : 18'(base + i);
         repeat (HALF) @(posedge ref_clk);
         write_clk <= 1'b1;
         repeat (HALF) @(posedge ref_clk);
         write_clk <= 1'b0;
      end
      write_en_n <= 1'b1;
      write_data <= ~write_data;
      repeat (HALF) @(posedge ref_clk);
   endtask
   // reader requests each word with a low read enable
   task automatic rd(input int n, input logic enN);
      for (int i = 0; i < n; i++) begin
         read_en_n <= enN;
         repeat (HALF) @(posedge ref_clk);
         read_clk <= 1'b1;
         repeat (HALF) @(posedge ref_clk);
         read_clk <= 1'b0;
      end
      read_en_n <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

//--- tb/dcf_read_flags_test.sv
// bench for the dual clock buffer: link traffic, flags, offsets over apb
// assumes the link agent model; all apb and strap inputs move at ref_clk rise
`default_nettype none
module dcf_read_flags_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic fall_through_mode = 1'b0, offset_access_n = 1'b1, serial_load_en_n = 1'b1;
   logic output_en_n = 1'b0, master_reset_n = 1'b1, partial_reset_n = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, serr, readDataOe;
   logic emptyFlag_n, fullFlag_n, almostEmpty_n, almostFull_n, halfFull_n;
   logic write_clk, read_clk, write_en_n, read_en_n;
   logic [17:0] write_data, read_data;
   logic [25:0] sv; // serial offset image {full, empty}
   int fail_count = 0;
   int comparisons = 0;
   // 50 MHz system clock
   always #10 ref_clk = ~ref_clk;
   dcf_link_agent dcf_link_agent_inst (.ref_clk(ref_clk), .write_clk(write_clk),
      .read_clk(read_clk),
      .write_en_n(write_en_n), .read_en_n(read_en_n), .write_data(write_data));
   dcf_read_flags dcf_read_flags_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .write_clk(write_clk), .read_clk(read_clk), .write_en_n(write_en_n),
      .read_en_n(read_en_n), .write_data(write_data), .fall_through_mode(fall_through_mode),
      .offset_access_n(offset_access_n), .serial_load_en_n(serial_load_en_n),
      .output_en_n(output_en_n), .master_reset_n(master_reset_n),
      .partial_reset_n(partial_reset_n), .read_data(read_data), .readDataOe(readDataOe),
      .emptyFlag_n(emptyFlag_n), .fullFlag_n(fullFlag_n), .almostEmpty_n(almostEmpty_n),
      .almostFull_n(almostFull_n), .halfFull_n(halfFull_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // single compare point; case inequality keeps unknowns from matching
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // only the watchdog ends a wait that never sees pready
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // flag vector {empty, full, almost empty, almost full, half full}
   task automatic flags(input logic [4:0] exp);
      chk(32'({emptyFlag_n, fullFlag_n, almostEmpty_n, almostFull_n, halfFull_n}), 32'(exp));
   endtask
   // master reset with straps held steady well past the synchronisers
   task automatic mreset(input logic ft, input logic ld);
      @(posedge ref_clk);
      master_reset_n <= 1'b0;
      fall_through_mode <= ft;
      offset_access_n <= ld;
      repeat (6) @(posedge ref_clk);
      master_reset_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      offset_access_n <= 1'b1;
   endtask
   task automatic give_verdict();
      if (fail_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // watchdog: the longest scenario is about 34k cycles
   initial begin
      repeat (60000) @(posedge ref_clk);
      fail_count++;
      give_verdict();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      mreset(1'b0, 1'b0);
      flags(5'b01011);
      rdchk(dcf_pkg::A_STATUS, 32'h1a);
      chk(32'(read_data), 32'h0);
      chk(32'($bits(read_data)), 32'd18);
      rdchk(dcf_pkg::A_EMPTY_OFF, 32'h7f);
      rdchk(dcf_pkg::A_FULL_OFF, 32'h7f);
      rdchk(8'h10, 32'h0);
      chk(32'(serr), 32'h1);
      // parallel offsets: empty 2, full 8190 so almost full after 2 words
      @(posedge ref_clk);
      offset_access_n <= 1'b0;
      apb(1'b1, dcf_pkg::A_EMPTY_OFF, 32'h2);
      apb(1'b1, dcf_pkg::A_FULL_OFF, 32'h1ffe);
      rdchk(dcf_pkg::A_FULL_OFF, 32'h1ffe);
      @(posedge ref_clk);
      offset_access_n <= 1'b1;
      dcf_link_agent_inst.rd(1, 1'b0);
      chk(32'({emptyFlag_n, read_data}), 32'h0);
      dcf_link_agent_inst.wr(1, 18'h100, 1'b0);
      dcf_link_agent_inst.rd(1, 1'b1);
      chk(32'(emptyFlag_n), 32'h0);
      dcf_link_agent_inst.rd(1, 1'b1);
      chk(32'(emptyFlag_n), 32'h1);
      dcf_link_agent_inst.wr(2, 18'h101, 1'b0);
      // two read edges carry the new write pointer across
      dcf_link_agent_inst.rd(2, 1'b1);
      flags(5'b11101);
      rdchk(dcf_pkg::A_LEVEL, 32'h30003);
      chk(32'(read_data), 32'h0);
      for (int i = 0; i < 3; i++) begin
         dcf_link_agent_inst.rd(1, 1'b0);
         chk(32'(read_data), 32'h100 + i);
      end
      dcf_link_agent_inst.rd(1, 1'b0);
      chk(32'({emptyFlag_n, almostEmpty_n, read_data}), 32'h102);
      // output drive enable toggled with data standing
      @(posedge ref_clk);
      output_en_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(32'(readDataOe), 32'h0);
      output_en_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(32'(readDataOe), 32'h1);
      // partial reset keeps offsets, clears data and flags
      partial_reset_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      partial_reset_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      flags(5'b01011);
      chk(32'(read_data), 32'h0);
      rdchk(dcf_pkg::A_EMPTY_OFF, 32'h2);
      dcf_link_agent_inst.wr(4096, 18'h0, 1'b0);
      chk(32'(halfFull_n), 32'h1);
      dcf_link_agent_inst.wr(1, 18'h0, 1'b0);
      chk(32'({fullFlag_n, halfFull_n}), 32'h2);
      // read side must see the writes before a read can take a word
      dcf_link_agent_inst.rd(2, 1'b1);
      dcf_link_agent_inst.rd(1, 1'b0);
      chk(32'(halfFull_n), 32'h1);
      // fall-through mode with serial offset loading
      mreset(1'b1, 1'b1);
      flags(5'b10011);
      rdchk(dcf_pkg::A_FULL_OFF, 32'h3ff);
      @(posedge ref_clk);
      offset_access_n <= 1'b0;
      apb(1'b1, dcf_pkg::A_EMPTY_OFF, 32'h5);
      rdchk(dcf_pkg::A_EMPTY_OFF, 32'h3ff);
      sv = {13'h1ffe, 13'h0001};
      serial_load_en_n <= 1'b0;
      for (int i = 25; i >= 0; i--) begin
         @(posedge ref_clk);
         fall_through_mode <= sv[i];
         dcf_link_agent_inst.wr(1, 18'h0, 1'b1);
      end
      @(posedge ref_clk);
      serial_load_en_n <= 1'b1;
      dcf_link_agent_inst.wr(3, 18'h0, 1'b1);
      rdchk(dcf_pkg::A_EMPTY_OFF, 32'h1);
      rdchk(dcf_pkg::A_FULL_OFF, 32'h1ffe);
      @(posedge ref_clk);
      offset_access_n <= 1'b1;
      dcf_link_agent_inst.wr(1, 18'h2aa, 1'b0);
      dcf_link_agent_inst.rd(2, 1'b1);
      chk(32'(emptyFlag_n), 32'h1);
      dcf_link_agent_inst.rd(1, 1'b1);
      chk(32'({emptyFlag_n, read_data}), 32'h2aa);
      dcf_link_agent_inst.wr(2, 18'h155, 1'b0);
      dcf_link_agent_inst.rd(2, 1'b1);
      flags(5'b00101);
      dcf_link_agent_inst.rd(1, 1'b0);
      chk(32'(read_data), 32'h155);
      dcf_link_agent_inst.rd(1, 1'b0);
      chk(32'({emptyFlag_n, read_data}), 32'h156);
      dcf_link_agent_inst.rd(1, 1'b0);
      chk(32'({emptyFlag_n, read_data}), 32'h40156);
      give_verdict();
   end
endmodule
`default_nettype wire
